// ==== pkg/ffc_pkg.sv ====
// Functional notes
// - Reset may change at any moment.
// - Reset clears pointers; full/empty/almost-empty low, almost-full high.
// - Reset drives both mail pending flags high.
// - Full flag rises second edge after release.
// - Offset register loads selects at release.
// - Port A drives only when select, write/read low.
// - FIFO write needs five qualifying port A conditions.
// - Port B drives only when select, write/read low.
// - Mail writes lower flags; opposite reads raise them.
// - Parity errors derived combinationally, follow odd/even.
// - Parity bits at 8, 17, 26, 35.
// - Mail1 write propagates onto driving port B.
// - Offset codes 11/10/01/00 give 16/12/8/4.
// - FIFO read needs five qualifying port B conditions.
// - FIFO writes ignored while full flag is low.
// - Mailbox select high writes mail1, not FIFO.
package ffc_pkg;
  localparam int DATA_W   = 36;
  localparam int DEPTH    = 64;
  localparam int ADDR_W   = 6;
  localparam int PTR_W    = 7;
  localparam int BYTE_W   = 9;
  localparam int LANES    = 4;
  localparam int PAR_POS  = 8;
  localparam int BUF_SLOTS = 2;
  localparam int RESET_MIN_EDGES = 4;
  localparam int FULL_RISE_EDGE  = 2;

  localparam logic [PTR_W-1:0] FIFO_DEPTH  = 7'h40;
  localparam logic [PTR_W-1:0] PTR_RESET   = 7'h00;
  localparam logic [PTR_W-1:0] PTR_STEP    = 7'h01;
  localparam logic [PTR_W-1:0] OFFSET_11   = 7'h10;
  localparam logic [PTR_W-1:0] OFFSET_10   = 7'h0C;
  localparam logic [PTR_W-1:0] OFFSET_01   = 7'h08;
  localparam logic [PTR_W-1:0] OFFSET_00   = 7'h04;
  localparam logic [PTR_W-1:0] OFFSET_RESET = OFFSET_00;
  localparam logic [DATA_W-1:0] MAIL_RESET = 36'h0_0000_0000;
  localparam logic [DATA_W-1:0] OUT_RESET  = 36'h0_0000_0000;

  typedef enum logic [1:0] {
    REL_CAPTURE = 2'b00,
    REL_WAIT    = 2'b01,
    REL_RUN     = 2'b10
  } ffc_release_type;

  function automatic logic [PTR_W-1:0] ffc_offset_decode(
    input logic hi,
    input logic lo
  );
    logic [PTR_W-1:0] val;
    unique case ({hi, lo})
      2'b11: val = OFFSET_11;
      2'b10: val = OFFSET_10;
      2'b01: val = OFFSET_01;
      2'b00: val = OFFSET_00;
    endcase
    return val;
  endfunction
endpackage

// ==== pkg/ffc_stream_if.sv ====
`timescale 1ns/100ps
interface ffc_stream_if;
  import ffc_pkg::*;
  logic              valid;
  logic              ready;
  logic [DATA_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== core/ffc_two_entry_buf.sv ====
`timescale 1ns/100ps
module ffc_two_entry_buf
  import ffc_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   reset_n,
  ffc_stream_if.snk   upstream,
  ffc_stream_if.src   downstream
);
  logic [DATA_W-1:0] slot0;
  logic [DATA_W-1:0] slot1;
  logic [1:0]        count;
  logic [DATA_W-1:0] next_slot0;
  logic [DATA_W-1:0] next_slot1;
  logic [1:0]        next_count;
  logic              push;
  logic              pop;

  // Ready stalls the memory side so a stalled reader drops nothing
  assign upstream.ready   = (count != 2'h2);
  assign downstream.valid = (count != 2'h0);
  assign downstream.data  = slot0;
  assign push = upstream.valid && upstream.ready;
  assign pop  = downstream.valid && downstream.ready;

  always_comb begin
    next_slot0 = slot0;
    next_slot1 = slot1;
    next_count = count;
    if (pop) begin
      next_slot0 = slot1;
    end
    if (push) begin
      if (count == 2'h0 || (count == 2'h1 && pop)) begin
        next_slot0 = upstream.data;
      end else begin
        next_slot1 = upstream.data;
      end
    end
    next_count = 2'(count + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slot0 <= OUT_RESET;
      slot1 <= OUT_RESET;
      count <= 2'h0;
    end else begin
      slot0 <= next_slot0;
      slot1 <= next_slot1;
      count <= next_count;
    end
  end

  a_buf_no_overflow:
  assert property (@(posedge clk) disable iff (!reset_n)
    (count == 2'h2 && !pop) |=> count == 2'h2 && !upstream.ready)
  else $error("Buffer lost or overran a word");
endmodule

// ==== core/ffc_parity_check.sv ====
`timescale 1ns/100ps
module ffc_parity_check
  import ffc_pkg::*;
(
  input  wire logic [DATA_W-1:0] wordIn,
  input  wire logic              oddSel,
  input  wire logic              genEn,
  output logic      [DATA_W-1:0] wordOut,
  output logic                   parityError
);
  logic [LANES-1:0] laneBad;

  for (genvar k = 0; k < LANES; k++) begin : g_lane
    localparam int LO = k * BYTE_W;
    localparam int PB = LO + PAR_POS;
    logic dataXor;
    assign dataXor = ^wordIn[PB-1:LO];
    assign wordOut[PB-1:LO] = wordIn[PB-1:LO];
    assign wordOut[PB] = genEn ? (dataXor ^ oddSel) : wordIn[PB];
    assign laneBad[k] = (^wordOut[PB:LO]) != oddSel;
  end

  assign parityError = |laneBad;
endmodule

// ==== core/ffc_fifo_port_ctrl.sv ====
`timescale 1ns/100ps
module ffc_fifo_port_ctrl
  import ffc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              portAChipSelectLow,
  input  wire logic              portAWriteReadSel,
  input  wire logic              portAStrobe,
  input  wire logic              portAMailboxSelect,
  input  wire logic [DATA_W-1:0] portADataIn,
  output logic      [DATA_W-1:0] portADataOut,
  output logic                   portADataOe,
  input  wire logic              portBChipSelectLow,
  input  wire logic              portBWriteReadSel,
  input  wire logic              portBStrobe,
  input  wire logic              portBSizeSelHi,
  input  wire logic              portBSizeSelLo,
  input  wire logic [DATA_W-1:0] portBDataIn,
  output logic      [DATA_W-1:0] portBDataOut,
  output logic                   portBDataOe,
  input  wire logic              offsetSelectHi,
  input  wire logic              offsetSelectLo,
  input  wire logic              parityOddSel,
  input  wire logic              portAParityGenerate,
  input  wire logic              portBParityGenerate,
  output logic                   fullFlagLow,
  output logic                   almostFullLow,
  output logic                   emptyFlagLow,
  output logic                   almostEmptyLow,
  output logic                   mail1PendingLow,
  output logic                   mail2PendingLow,
  output logic                   portAParityError,
  output logic                   portBParityError
);
  localparam int SYNC_W = 2 * DATA_W + 14;

  // Pin synchronisers; no reset so data pins keep loading through reset
  logic [SYNC_W-1:0] syncMeta;
  logic [SYNC_W-1:0] syncHold;
  logic              port_a_chip_select_low;
  logic              wrA;
  logic              stbA;
  logic              mbxA;
  logic [DATA_W-1:0] dataA;
  logic              port_b_chip_select_low;
  logic              wrB;
  logic              stbB;
  logic              szHi;
  logic              szLo;
  logic [DATA_W-1:0] dataB;
  logic              fsHi;
  logic              fsLo;
  logic              oddSel;
  logic              port_a_parity_generate;
  logic              port_b_parity_generate;

  always_ff @(posedge clk) begin
    syncMeta <= {portAChipSelectLow, portAWriteReadSel, portAStrobe,
                 portAMailboxSelect, portADataIn,
                 portBChipSelectLow, portBWriteReadSel, portBStrobe,
                 portBSizeSelHi, portBSizeSelLo, portBDataIn,
                 offsetSelectHi, offsetSelectLo, parityOddSel,
                 portAParityGenerate, portBParityGenerate};
    syncHold <= syncMeta;
  end

  assign {port_a_chip_select_low, wrA, stbA, mbxA, dataA, port_b_chip_select_low, wrB, stbB, szHi, szLo,
          dataB, fsHi, fsLo, oddSel, port_a_parity_generate, port_b_parity_generate} = syncHold;

  // Storage and state
  logic [DATA_W-1:0] mem [DEPTH];
  ffc_release_type   relState;
  ffc_release_type   next_relState;
  logic [PTR_W-1:0]  wrPtr;
  logic [PTR_W-1:0]  next_wrPtr;
  logic [PTR_W-1:0]  rdPtr;
  logic [PTR_W-1:0]  next_rdPtr;
  logic [PTR_W-1:0]  offset;
  logic [PTR_W-1:0]  next_offset;
  logic [DATA_W-1:0] mail1;
  logic [DATA_W-1:0] next_mail1;
  logic [DATA_W-1:0] mail2;
  logic [DATA_W-1:0] next_mail2;
  logic              next_mail1PendingLow;
  logic              next_mail2PendingLow;
  logic [DATA_W-1:0] portBOut;
  logic [DATA_W-1:0] next_portBOut;
  logic [PTR_W-1:0]  fill;
  logic              running;
  logic              bothSize;
  logic              wrFifo;
  logic              wrMail1;
  logic              rdMail2;
  logic              rdFifo;
  logic              wrMail2;
  logic              rdMail1;
  logic              popMem;
  logic [DATA_W-1:0] wordA;
  logic [DATA_W-1:0] wordB;
  logic [DATA_W-1:0] driveB;

  ffc_stream_if memToBuf ();
  ffc_stream_if bufToOut ();

  // requests held off until release sequence ends
  assign running  = (relState == REL_RUN);
  assign bothSize = szHi && szLo;
  assign fill     = 7'(wrPtr - rdPtr);

  // flags follow reset values of the pointers
  // full flag only high once running
  assign fullFlagLow    = running && (fill != FIFO_DEPTH);
  assign almostFullLow  = 7'(FIFO_DEPTH - fill) > offset;
  assign almostEmptyLow = fill > offset;
  assign emptyFlagLow   = running && bufToOut.valid;

  // full flag low blocks the write
  assign wrFifo  = !port_a_chip_select_low && wrA && stbA && !mbxA && fullFlagLow;
  assign wrMail1 = !port_a_chip_select_low && wrA && stbA && mbxA && running;
  assign rdMail2 = !port_a_chip_select_low && !wrA && stbA && mbxA && running;
  assign rdFifo  = !port_b_chip_select_low && !wrB && stbB && emptyFlagLow && !bothSize;
  assign wrMail2 = !port_b_chip_select_low && wrB && stbB && bothSize && running;
  assign rdMail1 = !port_b_chip_select_low && !wrB && stbB && bothSize && running;

  // Memory feeds the two-entry buffer; reader stalls hold it full
  assign memToBuf.valid = (wrPtr != rdPtr);
  assign memToBuf.data  = mem[rdPtr[ADDR_W-1:0]];
  assign popMem         = memToBuf.valid && memToBuf.ready;
  assign bufToOut.ready = rdFifo;

  ffc_two_entry_buf u_buf (
    .clk        (clk),
    .reset_n    (reset_n),
    .upstream   (memToBuf),
    .downstream (bufToOut)
  );

  always_ff @(posedge clk) begin
    if (wrFifo) begin
      mem[wrPtr[ADDR_W-1:0]] <= dataA;
    end
  end

  always_comb begin
    next_relState        = relState;
    next_wrPtr           = wrPtr;
    next_rdPtr           = rdPtr;
    next_offset          = offset;
    next_mail1           = mail1;
    next_mail2           = mail2;
    next_mail1PendingLow = mail1PendingLow;
    next_mail2PendingLow = mail2PendingLow;
    next_portBOut        = portBOut;
    unique case (relState)
      REL_CAPTURE: begin
        next_offset   = ffc_offset_decode(fsHi, fsLo);
        next_relState = REL_WAIT;
      end
      REL_WAIT: begin
        next_relState = REL_RUN;
      end
      REL_RUN: begin
        next_relState = REL_RUN;
      end
      default: begin
        next_relState = REL_CAPTURE;
      end
    endcase
    if (wrFifo) begin
      next_wrPtr = 7'(wrPtr + PTR_STEP);
    end
    if (popMem) begin
      next_rdPtr = 7'(rdPtr + PTR_STEP);
    end
    if (rdFifo) begin
      next_portBOut = bufToOut.data;
    end
    // mail writes win over reads in one cycle
    if (wrMail1) begin
      next_mail1           = dataA;
      next_mail1PendingLow = 1'b0;
    end else if (rdMail1) begin
      next_mail1PendingLow = 1'b1;
    end
    if (wrMail2) begin
      next_mail2           = dataB;
      next_mail2PendingLow = 1'b0;
    end else if (rdMail2) begin
      next_mail2PendingLow = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      relState        <= REL_CAPTURE;
      wrPtr           <= PTR_RESET;
      rdPtr           <= PTR_RESET;
      offset          <= OFFSET_RESET;
      mail1           <= MAIL_RESET;
      mail2           <= MAIL_RESET;
      mail1PendingLow <= 1'b1;
      mail2PendingLow <= 1'b1;
      portBOut        <= OUT_RESET;
    end else begin
      relState        <= next_relState;
      wrPtr           <= next_wrPtr;
      rdPtr           <= next_rdPtr;
      offset          <= next_offset;
      mail1           <= next_mail1;
      mail2           <= next_mail2;
      mail1PendingLow <= next_mail1PendingLow;
      mail2PendingLow <= next_mail2PendingLow;
      portBOut        <= next_portBOut;
    end
  end

  // port A drives only with both low
  assign portADataOe = !port_a_chip_select_low && !wrA;
  // port B drives only with both low
  assign portBDataOe = !port_b_chip_select_low && !wrB;

  // mail1 goes straight to port B
  assign driveB = bothSize ? mail1 : portBOut;
  assign wordA  = portADataOe ? mail2 : dataA;
  assign wordB  = portBDataOe ? driveB : dataB;

  ffc_parity_check u_par_a (
    .wordIn      (wordA),
    .oddSel      (oddSel),
    .genEn       (port_a_parity_generate && portADataOe),
    .wordOut     (portADataOut),
    .parityError (portAParityError)
  );

  ffc_parity_check u_par_b (
    .wordIn      (wordB),
    .oddSel      (oddSel),
    .genEn       (port_b_parity_generate && portBDataOe && bothSize),
    .wordOut     (portBDataOut),
    .parityError (portBParityError)
  );

  // Sampled reset_n keeps the release edge itself out of the check
  a_full_release:
  assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && relState == REL_CAPTURE |-> !fullFlagLow ##1 !fullFlagLow
      ##1 fullFlagLow)
  else $error("Full flag not raised on second edge after reset");

  a_offset_load:
  assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && relState == REL_CAPTURE |=>
      offset == ffc_offset_decode($past(fsHi), $past(fsLo)))
  else $error("Offset not loaded from selects at release");

  a_hold_off:
  assert property (@(posedge clk) disable iff (!reset_n)
    !running |-> !fullFlagLow && !emptyFlagLow && !wrMail1 && !rdMail1)
  else $error("Request taken before release sequence ended");

  a_port_float:
  assert property (@(posedge clk) disable iff (!reset_n)
    (port_a_chip_select_low || wrA) |-> !portADataOe)
  else $error("Port A bus driven while deselected");

  a_port_b_float:
  assert property (@(posedge clk) disable iff (!reset_n)
    (port_b_chip_select_low || wrB) |-> !portBDataOe)
  else $error("Port B bus driven while deselected");

  a_fifo_write:
  assert property (@(posedge clk) disable iff (!reset_n)
    (!port_a_chip_select_low && wrA && stbA && !mbxA && fullFlagLow) |=>
      wrPtr == 7'($past(wrPtr) + PTR_STEP))
  else $error("Qualified write did not advance write pointer");

  a_full_ignore:
  assert property (@(posedge clk) disable iff (!reset_n)
    !fullFlagLow ##1 running |-> $stable(wrPtr))
  else $error("Write pointer moved while full flag low");

  a_mail1_write:
  assert property (@(posedge clk) disable iff (!reset_n)
    (!port_a_chip_select_low && wrA && stbA && mbxA && running) |=>
      !mail1PendingLow && mail1 == $past(dataA) && $stable(wrPtr))
  else $error("Mailbox write did not land in mail1");

  a_mail2_read:
  assert property (@(posedge clk) disable iff (!reset_n)
    (rdMail2 && !(!port_b_chip_select_low && wrB && stbB && bothSize)) |=> mail2PendingLow)
  else $error("Mail2 read did not raise its flag");

  a_fifo_read:
  assert property (@(posedge clk) disable iff (!reset_n)
    (!port_b_chip_select_low && !wrB && stbB && emptyFlagLow && !bothSize) |=>
      portBOut == $past(bufToOut.data))
  else $error("Qualified read did not load output register");

  a_mail1_pass:
  assert property (@(posedge clk) disable iff (!reset_n)
    (portBDataOe && bothSize && !port_b_parity_generate) |-> portBDataOut == mail1)
  else $error("Mail1 not presented on port B");

  a_par_gen_a:
  assert property (@(posedge clk) disable iff (!reset_n)
    (port_a_parity_generate && portADataOe) |-> !portAParityError)
  else $error("Generated parity flagged on port A");

  a_par_gen_b:
  assert property (@(posedge clk) disable iff (!reset_n)
    (port_b_parity_generate && portBDataOe && bothSize) |-> !portBParityError)
  else $error("Generated parity flagged on port B");
endmodule

// ==== tb/ffc_host_b.sv ====
`timescale 1ns/100ps
module ffc_host_b
  import ffc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              readEn,
  input  wire logic              mbxWrite,
  input  wire logic              mbxRead,
  input  wire logic              mbxView,
  input  wire logic [DATA_W-1:0] wordIn,
  input  wire logic              emptyFlagLow,
  output logic                   portBChipSelectLow,
  output logic                   portBWriteReadSel,
  output logic                   portBStrobe,
  output logic                   portBSizeSelHi,
  output logic                   portBSizeSelLo,
  output logic      [DATA_W-1:0] portBDataIn
);
  logic mbxSel;

  assign mbxSel = mbxWrite || mbxRead || mbxView;
  initial begin
    {portBChipSelectLow, portBWriteReadSel, portBStrobe} = 3'h4;
    {portBSizeSelHi, portBSizeSelLo} = 2'h0;
    portBDataIn = 36'h0_0000_0000;
  end
  always @(posedge clk) begin
    portBChipSelectLow <= !(readEn || mbxSel);
    portBWriteReadSel  <= mbxWrite;
    portBStrobe        <= mbxWrite || mbxRead || (readEn && emptyFlagLow);
    portBSizeSelHi     <= mbxSel;
    portBSizeSelLo     <= mbxSel;
    // Idle bus toggles so a stale word never looks valid
    portBDataIn        <= mbxWrite ? wordIn : ~portBDataIn;
  end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench
  import ffc_pkg::*;
;
  logic              clk;
  logic              resetN;
  logic              aCs, aWr, aStb, aMbx, aGen, bGen, oddSel;
  logic              offHi, offLo, readEn, bWr, bRd, bView, fifoWatch;
  logic              oeA, oeB, bCs, bWrRd, bStb, bHi, bLo, peA, peB;
  logic              fullN, afullN, emptyN, aemptyN, mail1N, mail2N;
  logic [DATA_W-1:0] aDrive, bWord, busA, busB, hostB, outA, outB, lastB;
  logic [DATA_W-1:0] expQ[$];
  logic [31:0]       seed;
  int                errorCnt;
  int                nTests;

  always #2.5 clk = ~clk;
  // Shared bus level from both parties
  assign busA = oeA ? outA : aDrive;
  assign busB = oeB ? outB : hostB;

  ffc_fifo_port_ctrl ffc_fifo_port_ctrl_i (
    .clk                 (clk),
    .reset_n             (resetN),
    .portAChipSelectLow  (aCs),
    .portAWriteReadSel   (aWr),
    .portAStrobe         (aStb),
    .portAMailboxSelect  (aMbx),
    .portADataIn         (busA),
    .portADataOut        (outA),
    .portADataOe         (oeA),
    .portBChipSelectLow  (bCs),
    .portBWriteReadSel   (bWrRd),
    .portBStrobe         (bStb),
    .portBSizeSelHi      (bHi),
    .portBSizeSelLo      (bLo),
    .portBDataIn         (busB),
    .portBDataOut        (outB),
    .portBDataOe         (oeB),
    .offsetSelectHi      (offHi),
    .offsetSelectLo      (offLo),
    .parityOddSel        (oddSel),
    .portAParityGenerate (aGen),
    .portBParityGenerate (bGen),
    .fullFlagLow         (fullN),
    .almostFullLow       (afullN),
    .emptyFlagLow        (emptyN),
    .almostEmptyLow      (aemptyN),
    .mail1PendingLow     (mail1N),
    .mail2PendingLow     (mail2N),
    .portAParityError    (peA),
    .portBParityError    (peB)
  );

  ffc_host_b ffc_host_b_i (
    .clk                (clk),
    .readEn             (readEn),
    .mbxWrite           (bWr),
    .mbxRead            (bRd),
    .mbxView            (bView),
    .wordIn             (bWord),
    .emptyFlagLow       (emptyN),
    .portBChipSelectLow (bCs),
    .portBWriteReadSel  (bWrRd),
    .portBStrobe        (bStb),
    .portBSizeSelHi     (bHi),
    .portBSizeSelLo     (bLo),
    .portBDataIn        (hostB)
  );

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction

  function automatic logic parErr(
    input logic [DATA_W-1:0] v,
    input logic              odd
  );
    logic e;
    e = 1'b0;
    for (int i = 0; i < LANES; i++)
      e |= (^v[i*BYTE_W +: BYTE_W]) != odd;
    return e;
  endfunction

  function automatic logic [DATA_W-1:0] genPar(
    input logic [DATA_W-1:0] v,
    input logic              odd
  );
    for (int i = 0; i < LANES; i++)
      v[i*BYTE_W+PAR_POS] = (^v[i*BYTE_W +: PAR_POS]) ^ odd;
    return v;
  endfunction

  task automatic check(input logic [DATA_W-1:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Counts: %0d compares, %0d mismatches", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic doReset(input logic hi, input logic lo);
    offHi <= hi;
    offLo <= lo;
    {aCs, aWr, aStb, aMbx, bWr} <= 5'h0F;
    #1.2 resetN = 1'b0;
    tick(14);
    check({fullN, emptyN, aemptyN, afullN}, 4'h1);
    check({mail1N, mail2N}, 2'h3);
    {aStb, bWr} <= 2'h0;
    tick(6);
    resetN <= 1'b1;
    tick(1);
    #1 check(fullN, 1'b0);
    tick(1);
    #1 check(fullN, 1'b1);
    tick(4);
    check({mail1N, mail2N}, 2'h3);
  endtask

  task automatic writeA(
    input logic              mbx,
    input logic [DATA_W-1:0] w,
    input int                gap
  );
    {aCs, aWr, aStb, aMbx} <= {3'h3, mbx};
    aDrive <= w;
    tick(1);
    aStb <= 1'b0;
    aDrive <= ~w;
    tick(gap);
  endtask

  task automatic drain();
    for (int i = 0; i < 2000 && expQ.size() > 0; i++)
      tick(1);
    if (expQ.size() > 0) begin
      errorCnt++;
      summarize();
    end
    tick(10);
  endtask

  // Oldest note is compared when the read word shows up
  always @(posedge clk) begin
    if (fifoWatch && oeB && outB !== lastB) begin
      if (expQ.size() > 0)
        check(outB, expQ.pop_front());
      else
        check(outB, lastB);
      lastB = outB;
    end
  end

  initial begin
    logic [DATA_W-1:0] w;
    int                acc;
    {clk, resetN, aCs, aWr, aStb, aMbx, aGen, bGen, oddSel} = 9'h040;
    {offHi, offLo, readEn, bWr, bRd, bView, fifoWatch} = 7'h00;
    aDrive = 36'h0_0000_0000;
    bWord = 36'h0_0000_0000;
    lastB = 36'h0_0000_0000;
    seed = 32'h0000_003B;
    errorCnt = 0;
    nTests = 0;
    for (int c = 0; c < 4; c++) begin
      doReset(c[1], c[0]);
      for (int i = 0; i < 4 * c + 4 + BUF_SLOTS; i++)
        writeA(1'b0, 36'h0_0000_0100, 5);
      check(aemptyN, 1'b0);
      writeA(1'b0, 36'h0_0000_0100, 5);
      check(aemptyN, 1'b1);
    end
    $display("test reset and offsets done");
    for (int i = 0; i < 4; i++) begin
      {aCs, aWr} <= i[1:0];
      tick(4);
      check(oeA, i == 0);
    end
    bWr <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      w = {seed, seed[3:0]};
      aDrive <= w;
      bWord <= ~w;
      oddSel <= seed[7];
      tick(5);
      check(peA, parErr(w, oddSel));
      check(peB, parErr(~w, oddSel));
    end
    check(oeB, 1'b0);
    bWr <= 1'b0;
    w = ~w;
    {aCs, aWr, aMbx, aGen} <= 4'h1;
    tick(5);
    check(mail2N, 1'b0);
    check(outA, genPar(w, oddSel));
    check(peA, 1'b0);
    {aMbx, aStb} <= 2'h3;
    tick(1);
    aStb <= 1'b0;
    tick(5);
    check(mail2N, 1'b1);
    // Port A must stop driving before mail1 data goes on its bus
    aWr <= 1'b1;
    bView <= 1'b1;
    tick(5);
    check(oeB, 1'b1);
    seed = xs(seed);
    w = {seed[3:0], seed};
    writeA(1'b1, w, 5);
    check(mail1N, 1'b0);
    check(outB, w);
    bGen <= 1'b1;
    tick(5);
    check(outB, genPar(w, oddSel));
    {bView, bRd} <= 2'h1;
    tick(1);
    bRd <= 1'b0;
    tick(5);
    check(mail1N, 1'b1);
    check(oeB, 1'b0);
    $display("test ports, parity and mail done");
    doReset(1'b1, 1'b1);
    // Output register holds its reset word until the first read
    lastB = OUT_RESET;
    fifoWatch = 1'b1;
    // Back-to-back writes, reader stalls at random
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      w = {i[7:0], seed[27:0]};
      expQ.push_back(w);
      {aCs, aWr, aMbx, aStb, aDrive, readEn} <= {4'h5, w, seed[31]};
      tick(1);
    end
    aStb <= 1'b0;
    readEn <= 1'b1;
    drain();
    readEn <= 1'b0;
    acc = 0;
    for (int i = 0; i < DEPTH + 6; i++) begin
      seed = xs(seed);
      w = {i[7:0], seed[27:0]};
      // only a write seen with space free lands
      if (fullN === 1'b1) begin
        expQ.push_back(w);
        acc++;
      end
      writeA(1'b0, w, 6);
    end
    check(acc >= DEPTH && acc <= DEPTH + BUF_SLOTS, 1'b1);
    check({fullN, afullN}, 2'h0);
    readEn <= 1'b1;
    drain();
    check(emptyN, 1'b0);
    $display("test fifo stream done");
    summarize();
  end
endmodule
